//--- src/mode_ext_defs.svh
// Constants for the extended mode register one and two decoder
`ifndef MODE_EXT_DEFS_SVH
`define MODE_EXT_DEFS_SVH
`define EMR_WIDTH 19
`define EMR_ONE_SEL 3'h1
`define EMR_TWO_SEL 3'h2
`define EMR_ONE_RESET 19'h00000
`define EMR_TWO_RESET 19'h00000
`define EMR1_DLL_OFF_BIT 0
`define EMR1_DRV_LO_BIT 1
`define EMR1_RTT_B0_BIT 2
`define EMR1_AL_LO_BIT 3
`define EMR1_AL_HI_BIT 4
`define EMR1_DRV_HI_BIT 5
`define EMR1_RTT_B1_BIT 6
`define EMR1_WLEVEL_BIT 7
`define EMR1_RTT_B2_BIT 9
`define EMR1_TSTROBE_BIT 11
`define EMR1_QOFF_BIT 12
`define EMR2_CWL_LO_BIT 3
`define EMR2_ASR_BIT 6
`define EMR2_SRT_BIT 7
`define EMR2_RTTWR_LO_BIT 9
`define EMR2_RTTWR_HI_BIT 10
`define DLL_OFF_LATENCY 4'h6
`endif

//--- src/mode_ext_pkg.sv
// Types shared by the extended mode register decoder
package mode_ext_pkg;
   // Nominal termination choice, reference divided by n
   typedef enum logic [2:0] {
      RTT_OFF = 3'h0, RTT_DIV4 = 3'h1, RTT_DIV2 = 3'h2, RTT_DIV6 = 3'h3,
      RTT_DIV12 = 3'h4, RTT_DIV8 = 3'h5, RTT_RSV6 = 3'h6, RTT_RSV7 = 3'h7
   } rtt_sel_t;
   // Additive latency choice
   typedef enum logic [1:0] {
      AL_ZERO = 2'h0, AL_CL_M1 = 2'h1, AL_CL_M2 = 2'h2, AL_RSV = 2'h3
   } al_sel_t;
   // Self refresh DLL tracking states
   typedef enum logic [2:0] {
      DLL_ST_RUN = 3'b001, DLL_ST_SLEEP = 3'b010, DLL_ST_OFF = 3'b100
   } dll_state_t;
   // Decoded settings travelling together
   typedef struct packed {
      logic dll_on;
      logic [1:0] drive_sel;
      al_sel_t al_sel;
      logic write_level;
      logic term_strobe;
      logic out_off;
      rtt_sel_t rtt_nom;
      logic [2:0] cwl_code;
      logic asr_en;
      logic srt_en;
      logic [1:0] rtt_wr;
   } mode_cfg_t;
endpackage

//--- src/mode_ext_regs.sv
// Extended mode registers one and two: storage, decode and termination control
//
// What this block does
// - Register one held until rewrite or reset
// - Leveling limits termination unless outputs off
// - Running DLL sleeps and restarts across self refresh
// - Disabled DLL stays off after self refresh
// - DLL off: no termination, latency six
// - Bits five and one pick drive strength
// - Output-off bit tri-states data and strobes
// - Termination strobe replaces data mask function
// - Bits nine, six, two pick termination
// - Termination gated; write value substitutes
// - Termination follows sampled termination pin
// - Bit seven enters write leveling
// - Bits four, three pick additive latency
// - Register two held until rewritten
// - Register two sets write latency
// - Dynamic write termination per burst
`timescale 1ns/1ps
`default_nettype none
`include "mode_ext_defs.svh"
module mode_ext_regs
   import mode_ext_pkg::*;
(
   input wire logic clk_i, // Command clock
   input wire logic rst_i, // Sync reset, high (reset pin low)
   input wire logic mrs_i, // Mode register load command, one cycle
   input wire logic [2:0] bank_i, // Bank lines pick the register
   input wire logic [18:0] addr_i, // Address lines carry the value
   input wire logic sr_enter_i, // Self refresh entry pulse
   input wire logic sr_exit_i, // Self refresh exit pulse
   input wire logic init_done_i, // Init and calibration finished
   input wire logic read_busy_i, // Read burst in flight
   input wire logic write_busy_i, // Write burst in flight
   input wire logic odt_pin_i, // Termination pin, asynchronous
   output logic [18:0] emr_one_o, // Stored register one
   output logic [18:0] emr_two_o, // Stored register two
   output var mode_cfg_t cfg_o, // Decoded settings
   output logic dll_active_o, // DLL running
   output logic dll_reset_o, // DLL reset request pulse
   output logic out_oe_allow_o, // Data and strobe may drive
   output logic data_mask_en_o, // Mask function on shared ball
   output logic strobe_term_en_o, // Termination on strobe pair
   output logic term_on_o, // Termination applied now
   output logic [2:0] term_sel_o, // Active termination code
   output logic [3:0] read_cl_cap_o, // Forced latency, 0 when free
   output logic [4:0] write_lat_add_o // Additive part of write latency
);
   logic [18:0] one_reg, one_next; // Register one storage
   logic [18:0] two_reg, two_next; // Register two storage
   dll_state_t dll_reg, dll_next; // DLL tracking state
   logic dllrst_reg, dllrst_next; // DLL reset pulse
   logic odt_s1_reg, odt_s2_reg; // Pin synchroniser
   logic term_reg, term_next; // Termination enable
   logic [2:0] tsel_reg, tsel_next; // Termination code
   mode_cfg_t cfg; // Combinational decode

   // Decode termination field from the three scattered bits
   function automatic rtt_sel_t rtt_of(input logic [18:0] r);
      rtt_of = rtt_sel_t'({r[`EMR1_RTT_B2_BIT], r[`EMR1_RTT_B1_BIT], r[`EMR1_RTT_B0_BIT]});
   endfunction

   // Register loads; reserved bits stored as written, controller keeps them zero
   always_comb begin
      one_next = one_reg;
      two_next = two_reg;
      if (mrs_i && bank_i == `EMR_ONE_SEL) begin
         one_next = addr_i;
      end
      if (mrs_i && bank_i == `EMR_TWO_SEL) begin
         two_next = addr_i;
      end
   end

   // Reset clears register one; register two only loses state at power loss
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         one_reg <= `EMR_ONE_RESET;
      end else begin
         one_reg <= one_next;
      end
      two_reg <= two_next;
   end

   // Field decode
   always_comb begin
      cfg.dll_on = ~one_reg[`EMR1_DLL_OFF_BIT];
      cfg.drive_sel = {one_reg[`EMR1_DRV_HI_BIT], one_reg[`EMR1_DRV_LO_BIT]};
      cfg.al_sel = al_sel_t'(one_reg[`EMR1_AL_HI_BIT:`EMR1_AL_LO_BIT]);
      cfg.write_level = one_reg[`EMR1_WLEVEL_BIT];
      cfg.term_strobe = one_reg[`EMR1_TSTROBE_BIT];
      cfg.out_off = one_reg[`EMR1_QOFF_BIT];
      cfg.rtt_nom = rtt_of(one_reg);
      cfg.cwl_code = two_reg[`EMR2_CWL_LO_BIT+2:`EMR2_CWL_LO_BIT];
      cfg.asr_en = two_reg[`EMR2_ASR_BIT];
      cfg.srt_en = two_reg[`EMR2_SRT_BIT];
      cfg.rtt_wr = two_reg[`EMR2_RTTWR_HI_BIT:`EMR2_RTTWR_LO_BIT];
   end

   // DLL tracking across self refresh; exit from sleep restarts and resets
   always_comb begin
      dll_next = dll_reg;
      dllrst_next = 1'b0;
      case (dll_reg)
         DLL_ST_RUN: begin
            if (sr_enter_i) begin
               dll_next = DLL_ST_SLEEP;
            end else if (!cfg.dll_on) begin
               dll_next = DLL_ST_OFF;
            end
         end
         DLL_ST_SLEEP: begin
            if (sr_exit_i) begin
               dll_next = DLL_ST_RUN;
               dllrst_next = 1'b1;
            end
         end
         DLL_ST_OFF: begin
            // Self refresh exit alone never wakes it
            if (cfg.dll_on && !sr_enter_i) begin
               dll_next = DLL_ST_RUN;
            end
         end
         default: dll_next = DLL_ST_OFF;
      endcase
   end

   // Termination: synchronised pin, gated by state, write value substituted
   always_comb begin
      logic allowed;
      logic wl_ok;
      allowed = 1'b0;
      wl_ok = 1'b0;
      tsel_next = cfg.rtt_nom;
      // Leveling with outputs on: only write-capable values 2, 4, 6 usable
      wl_ok = !cfg.write_level || cfg.out_off ||
              (cfg.rtt_nom inside {RTT_DIV2, RTT_DIV4, RTT_DIV6});
      allowed = init_done_i && !read_busy_i && dll_reg == DLL_ST_RUN;
      if (write_busy_i && cfg.rtt_wr != 2'h0 && !cfg.write_level) begin
         tsel_next = {1'b0, cfg.rtt_wr};
      end
      term_next = allowed && wl_ok && odt_s2_reg && tsel_next != 3'h0;
   end

   // Pin synchroniser, DLL and termination registers
   always_ff @(posedge clk_i) begin
      odt_s1_reg <= odt_pin_i;
      odt_s2_reg <= odt_s1_reg;
      if (rst_i) begin
         dll_reg <= DLL_ST_OFF;
         dllrst_reg <= 1'b0;
         term_reg <= 1'b0;
         tsel_reg <= 3'h0;
      end else begin
         dll_reg <= dll_next;
         dllrst_reg <= dllrst_next;
         term_reg <= term_next;
         tsel_reg <= tsel_next;
      end
   end

   assign emr_one_o = one_reg;
   assign emr_two_o = two_reg;
   assign cfg_o = cfg;
   assign dll_active_o = dll_reg == DLL_ST_RUN;
   assign dll_reset_o = dllrst_reg;
   assign out_oe_allow_o = ~one_reg[`EMR1_QOFF_BIT];
   assign strobe_term_en_o = one_reg[`EMR1_TSTROBE_BIT];
   assign data_mask_en_o = ~one_reg[`EMR1_TSTROBE_BIT];
   assign term_on_o = term_reg;
   assign term_sel_o = tsel_reg;
   // Latency forced to six clocks while the DLL is off
   assign read_cl_cap_o = (dll_reg == DLL_ST_RUN) ? 4'h0 : `DLL_OFF_LATENCY;
   // Additive latency as a code: zero, or 1 or 2 less than CL
   assign write_lat_add_o = {3'h0, cfg.al_sel};

   // Assertions
   a_reg_one_load: assert property (@(posedge clk_i) disable iff (rst_i)
      mrs_i && bank_i == `EMR_ONE_SEL |=> emr_one_o == $past(addr_i))
      else $error("register one not loaded");
   a_reg_one_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(mrs_i && bank_i == `EMR_ONE_SEL) |=> $stable(emr_one_o))
      else $error("register one changed without load");
   a_reg_two_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(mrs_i && bank_i == `EMR_TWO_SEL) |=> $stable(emr_two_o))
      else $error("register two changed without load");
   a_qoff_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
      emr_one_o[`EMR1_QOFF_BIT] |-> !out_oe_allow_o)
      else $error("outputs enabled while disabled");
   a_mask_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
      strobe_term_en_o |-> !data_mask_en_o)
      else $error("mask active with termination strobe");
   // Entry with a running DLL parks it; exit from the parked state restarts it
   sequence s_sleep;
      dll_active_o && sr_enter_i ##1 !dll_active_o;
   endsequence
   sequence s_wake;
      dll_reg == DLL_ST_SLEEP && sr_exit_i;
   endsequence
   a_dll_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
      s_sleep |-> dll_reg == DLL_ST_SLEEP)
      else $error("DLL not parked in self refresh");
   a_dll_wake: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wake |=> dll_active_o && dll_reset_o)
      else $error("DLL not restarted after self refresh");
   a_dll_stays_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !dll_active_o && emr_one_o[`EMR1_DLL_OFF_BIT] |=> !dll_active_o)
      else $error("DLL woke while disabled");
   a_no_term_dll_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !dll_active_o |=> !term_on_o)
      else $error("termination with DLL off");
   a_term_follows_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      term_on_o |-> $past(odt_s2_reg) && !$past(read_busy_i))
      else $error("termination without pin or in read");
   a_level_limit: assert property (@(posedge clk_i) disable iff (rst_i)
      term_on_o && $past(cfg.write_level) && !$past(cfg.out_off)
      |-> term_sel_o inside {3'h1, 3'h2, 3'h3})
      else $error("leveling termination value not allowed");
endmodule
`default_nettype wire

//--- verif/mrs_ctrl_model.sv
// Memory controller model that issues mode register loads
`timescale 1ns/1ps
`default_nettype none
module mrs_ctrl_model #(
   parameter int GAP = 4, // Load delay wait before the next command
   parameter bit STROBE_PAIR = 1'b1 // Part has the termination strobe pair
) (
   input wire logic clk_i, // Command clock
   input wire logic busy_i, // Any burst in flight
   output logic mrs_o, // Load command pulse
   output logic [2:0] bank_o, // Register select
   output logic [18:0] addr_o // Value lines
);
   // Quiet command bus at time zero
   initial begin
      mrs_o = 1'b0;
      bank_o = 3'h0;
      addr_o = 19'h00000;
   end
   // One load; illegal settings are cleaned before they reach the bus
   task automatic load(input logic [2:0] b, input logic [18:0] v);
      logic [18:0] w;
      w = v;
      if (b == 3'h1) begin
         w = w & 19'h31AFF;
         if (w[4:3] == 2'h3) begin
            w[4] = 1'b0;
         end
         // Parts without the strobe pair must keep the feature off
         if (!STROBE_PAIR) begin
            w[11] = 1'b0;
         end
      end
      if (b == 3'h2) begin
         w = w & 19'h306F8;
         if (w[6] && w[7]) begin
            w[7] = 1'b0;
         end
      end
      // Never load while a burst runs
      while (busy_i) @(negedge clk_i);
      mrs_o = 1'b1;
      bank_o = b;
      addr_o = w;
      @(negedge clk_i);
      // Lines are reused by other commands, so show garbage after the load
      mrs_o = 1'b0;
      bank_o = ~b;
      addr_o = ~w;
      repeat (GAP) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

//--- verif/sdram_mode_reg_one_two_decode_tb.sv
// Self-checking bench for the extended mode register decoder
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_reg_one_two_decode_tb;
   import mode_ext_pkg::*;
   typedef struct packed {logic [2:0] bank; logic [18:0] val; logic [11:0] exp;} row_t;
   logic clk = 1'b0, rst = 1'b1, sr_enter = 1'b0, sr_exit = 1'b0, init_done = 1'b0;
   logic rd_busy = 1'b0, wr_busy = 1'b0, odt_pin = 1'b0, mrs;
   logic [2:0] bank, term_sel;
   logic [18:0] addr, emr_one, emr_two;
   logic dll_active, dll_reset, oe_allow, dm_en, st_en, term_on;
   logic [3:0] cl_cap;
   logic [4:0] wlat;
   mode_cfg_t cfg;
   int n_fail = 0, check_count = 0, k;
   // Decoded views of each register, packed for table compares
   wire [11:0] obs1 = {cfg.drive_sel, cfg.al_sel, cfg.rtt_nom, oe_allow, dm_en, st_en, wlat[1:0]};
   wire [11:0] obs2 = {cfg.cwl_code, cfg.asr_en, cfg.srt_en, cfg.rtt_wr, 5'h00};
   // Drive codes 0 to 2, additive latency codes 0 to 2, termination codes 0 to 5 and write termination codes 1 to 3 are visited
   row_t rows [9] = '{'{3'h1, 19'h00002, 12'h418}, '{3'h1, 19'h0000C, 12'h139},
      '{3'h1, 19'h00070, 12'hA5A}, '{3'h1, 19'h00A04, 12'h0B4}, '{3'h1, 19'h01044, 12'h068},
      '{3'h1, 19'h00200, 12'h098}, '{3'h2, 19'h00248, 12'h320}, '{3'h2, 19'h004A0, 12'h8C0},
      '{3'h2, 19'h00618, 12'h660}};
   always #5 clk = ~clk;
   mrs_ctrl_model ctrl (.clk_i(clk), .busy_i(rd_busy | wr_busy), .mrs_o(mrs), .bank_o(bank),
      .addr_o(addr));
   mode_ext_regs mode_ext_regs_inst (.clk_i(clk), .rst_i(rst), .mrs_i(mrs), .bank_i(bank),
      .addr_i(addr), .sr_enter_i(sr_enter), .sr_exit_i(sr_exit), .init_done_i(init_done),
      .read_busy_i(rd_busy), .write_busy_i(wr_busy), .odt_pin_i(odt_pin), .emr_one_o(emr_one),
      .emr_two_o(emr_two), .cfg_o(cfg), .dll_active_o(dll_active), .dll_reset_o(dll_reset),
      .out_oe_allow_o(oe_allow), .data_mask_en_o(dm_en), .strobe_term_en_o(st_en),
      .term_on_o(term_on), .term_sel_o(term_sel), .read_cl_cap_o(cl_cap),
      .write_lat_add_o(wlat));
   // Compare and count; unknowns never match
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Single place where the run ends
   task automatic complete_run();
      $display("checks=%0d failures=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the 150 or so cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial begin
      cyc(10);
      rst = 1'b0;
      // Register two has no reset, so it gets a known value before anything else
      ctrl.load(3'h2, 19'h00000);
      chk(emr_two, 19'h00000);
      // Table pass; every row keeps the DLL enabled
      foreach (rows[i]) begin
         ctrl.load(rows[i].bank, rows[i].val);
         chk(rows[i].bank == 3'h1 ? emr_one : emr_two, rows[i].val);
         chk({7'h00, rows[i].bank == 3'h1 ? obs1 : obs2}, {7'h00, rows[i].exp});
      end
      // An unlisted select code must leave both registers alone
      ctrl.load(3'h3, 19'h00008);
      chk(emr_one, 19'h00200);
      chk(emr_two, 19'h00618);
      chk(cl_cap, 4'h0);
      // Termination follows the pin, write code overrides, reads suppress
      init_done = 1'b1;
      odt_pin = 1'b1;
      ctrl.load(3'h1, 19'h00004);
      cyc(4);
      chk({term_on, term_sel}, 4'h9);
      wr_busy = 1'b1;
      cyc(3);
      chk({term_on, term_sel}, 4'hB);
      wr_busy = 1'b0;
      rd_busy = 1'b1;
      cyc(3);
      chk(term_on, 1'b0);
      rd_busy = 1'b0;
      odt_pin = 1'b0;
      cyc(4);
      chk(term_on, 1'b0);
      // Leveling with outputs on keeps the /4 setting and ignores the write code
      odt_pin = 1'b1;
      ctrl.load(3'h1, 19'h00084);
      cyc(4);
      chk({term_on, term_sel}, 4'h9);
      wr_busy = 1'b1;
      cyc(3);
      chk({term_on, term_sel}, 4'h9);
      wr_busy = 1'b0;
      // Leveling with outputs on refuses the /12 setting, outputs off allow it
      ctrl.load(3'h1, 19'h00280);
      cyc(4);
      chk(term_on, 1'b0);
      chk(cfg.write_level, 1'b1);
      ctrl.load(3'h1, 19'h01280);
      cyc(4);
      chk({term_on, term_sel}, 4'hC);
      chk(oe_allow, 1'b0);
      // DLL off: capped latency, no termination, stays off across self refresh
      ctrl.load(3'h1, 19'h00005);
      cyc(3);
      chk(cl_cap, 4'h6);
      chk(term_on, 1'b0);
      sr_enter = 1'b1;
      cyc(1);
      sr_enter = 1'b0;
      sr_exit = 1'b1;
      cyc(1);
      sr_exit = 1'b0;
      cyc(3);
      chk(dll_active, 1'b0);
      // DLL enable, then a DLL reset load to register zero, which this block ignores
      ctrl.load(3'h1, 19'h00004);
      ctrl.load(3'h0, 19'h00100);
      chk(emr_one, 19'h00004);
      chk(dll_active, 1'b1);
      // Running DLL sleeps in self refresh and restarts with a reset pulse
      sr_enter = 1'b1;
      cyc(1);
      sr_enter = 1'b0;
      cyc(3);
      chk(dll_active, 1'b0);
      sr_exit = 1'b1;
      cyc(1);
      sr_exit = 1'b0;
      for (k = 0; k < 4 && dll_reset !== 1'b1; k++) @(negedge clk);
      chk(dll_reset, 1'b1);
      chk(dll_active, 1'b1);
      cyc(1);
      chk(dll_reset, 1'b0);
      // Reset clears register one only; the DLL restarts one edge after release
      rst = 1'b1;
      cyc(1);
      rst = 1'b0;
      chk(emr_one, 19'h00000);
      chk(emr_two, 19'h00618);
      chk({term_on, dll_reset, dll_active}, 3'h0);
      cyc(2);
      chk(dll_active, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
